// file: verilog/hbc_pkg.sv
// Shared constants and carrier types for the half-bridge serial control block
package hbc_pkg;

  // Widths
  localparam int NUM_SW    = 12;      // Six low-side plus six high-side switches
  localparam int WORD_W    = 16;      // Control and status word width
  localparam int BIT_CNT_W = 5;       // Serial bit counter, saturates at one full word
  localparam int TMR_W     = 18;      // Wide enough for the long short-circuit delay

  // Control word field positions
  localparam int CTL_CLEAR_BIT = 0;   // status_clear_bit
  localparam int CTL_SW_LSB    = 1;   // low_switch_one, then high_switch_one, alternating
  localparam int CTL_OL_BIT    = 13;  // open_load_enable_n
  localparam int CTL_SHORT_SEL = 14;  // short_delay_select
  localparam int CTL_RUN_BIT   = 15;  // Software run, low means standby

  // Status word field positions
  localparam int STS_PREWARN = 0;     // temp_prewarn_flag
  localparam int STS_SW_LSB  = 1;     // Per-switch state or open-load report
  localparam int STS_SHORT   = 13;    // short_detected_flag
  localparam int STS_STANDBY = 14;    // Combined standby state
  localparam int STS_SUPPLY  = 15;    // supply_fail_flag

  // Control reset value, overtemperature status image and frame length
  localparam logic [WORD_W-1:0] CTL_RESET = 16'he000;
  localparam logic [WORD_W-1:0] STS_ALL_HIGH = 16'hffff;
  localparam logic [BIT_CNT_W-1:0] FRAME_BITS = 5'h10;

  // Timing, internal oscillator rate and delays in microseconds
  localparam int CLK_KHZ        = 20000;
  localparam int SHORT_LONG_US  = 12000;  // short_shutdown_delay, long setting
  localparam int SHORT_SHORT_US = 1500;   // short_shutdown_delay, short setting
  localparam int UV_DELAY_US    = 20;     // undervoltage_delay
  localparam int SHORT_LONG_CYC  = (SHORT_LONG_US * CLK_KHZ) / 1000;
  localparam int SHORT_SHORT_CYC = (SHORT_SHORT_US * CLK_KHZ) / 1000;
  localparam int UV_DELAY_CYC    = (UV_DELAY_US * CLK_KHZ) / 1000;

  // Analog comparator outputs reaching the logic
  typedef struct packed {
    logic              uv;            // Power-stage supply below threshold
    logic              temp_warn;     // Prewarning comparator with hysteresis
    logic              temp_shut;     // Shutdown comparator with hysteresis
    logic [NUM_SW-1:0] over_current;  // Current limit active per switch
    logic [NUM_SW-1:0] open_load;     // Open-load comparator per switch
  } hbc_sense_t;

  localparam int SENSE_W = $bits(hbc_sense_t);

endpackage

// file: verilog/hbc_top.sv
// Serial control, protection and status logic of the hex half-bridge driver
`timescale 1ns/1ps

// Operation
// (RQ1) Chip select falling starts a new exchange
// (RQ2) Serial input sampled on falling clock, LSB first
// (RQ3) Control word applied on chip select rising
// (RQ4) Serial output tri-state while chip select high
// (RQ5) Status shifted LSB first, changes on rising
// (RQ6) Control bit 0 clears fail, short, overtemperature
// (RQ7) Bits 1 to 12 switch low/high sides
// (RQ8) Bit 13 low enables open-load detection
// (RQ9) Bit 14 selects long or short delay
// (RQ10) Software or pin inhibit forces standby
// (RQ11) Status bit 0 follows temperature prewarning
// (RQ12) Status 1 to 12 report switch or load
// (RQ13) Status bit 13 flags short-circuit shutdown
// (RQ14) Status bit 14 shows combined standby
// (RQ15) Status bit 15 flags supply undervoltage
// (RQ16) Overtemperature shutdown: all status high, outputs off
// (RQ17) Control resets to bits 15, 14, 13 high
// (RQ18) Undervoltage timer sets fail flag, disables outputs
// (RQ19) Switching on disables that output's open-load check
// (RQ20) Aborted transfer leaves words unchanged
// (RQ21) Overtemperature release needs cool-down and clear bit
// (RQ22) Short timer, immediate if prewarning, clearable
// (RQ23) Host keeps serial clock within maximum
// (RQ24) Delay timers count internal oscillator cycles
module hbc_top
  import hbc_pkg::*;
#(
  parameter int SHORT_LONG_CYCLES  = SHORT_LONG_CYC,
  parameter int SHORT_SHORT_CYCLES = SHORT_SHORT_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              serial_in,
  output logic                   serial_out,
  output logic                   serial_out_oe,
  input  wire logic              hard_standby_n,
  input  wire hbc_sense_t        sense,
  output logic [NUM_SW-1:0]      switch_on,
  output logic [NUM_SW-1:0]      open_load_pull,
  output logic                   standby
);

  // Link-side state, clocked by the serial clock
  logic [WORD_W-1:0]    rx_shift_ff;   // Incoming control bits
  logic [BIT_CNT_W-1:0] rx_cnt_ff;     // Falling edges seen in this frame
  logic                 frame_full_ff; // A whole word has been shifted in
  logic [3:0]           tx_idx_ff;     // Status bit currently on the line

  // Synchroniser stages into the oscillator domain
  localparam int SYNC_W = SENSE_W + 3;
  // Reset image of the crossing: chip select idle high, everything else low.
  // A zero here would look like a chip select rise right after reset and
  // could commit whatever word the shifter still holds from before.
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {{SENSE_W{1'b0}}, 3'h4};
  logic [SYNC_W-1:0]    meta_ff;       // First stage, read only by second stage
  logic [SYNC_W-1:0]    sync_ff;       // Second stage, safe to use

  // Synchronised views
  hbc_sense_t           sense_s;       // Analog flags after crossing
  logic                 cs_s;          // Chip select, high when idle
  logic                 inh_s;         // Hardware standby pin, low means standby
  logic                 full_s;        // Word-complete flag from the link

  // Oscillator-domain state
  logic                 cs_prev_ff;    // Previous chip select for edge detect
  logic [WORD_W-1:0]    ctrl_ff;       // bridge_control_word
  logic [WORD_W-1:0]    status_ff;     // bridge_status_word, frozen during a frame
  logic                 supply_fail_ff;
  logic                 short_flag_ff;
  logic                 overtemp_ff;   // Latched overtemperature shutdown
  logic [NUM_SW-1:0]    short_off_ff;  // Per-switch short-circuit shutdown
  logic [TMR_W-1:0]     uv_tmr_ff;     // Undervoltage delay timer
  logic                 uv_off_ff;     // Undervoltage persisted past the delay
  logic [NUM_SW-1:0]    switch_on_ff;
  logic [NUM_SW-1:0]    ol_pull_ff;
  logic                 standby_ff;

  // Combinational helpers
  logic                 commit;        // Complete word accepted this cycle
  logic                 clear_req;     // Committed word carries the clear bit
  logic [NUM_SW-1:0]    short_hit;     // Per-switch short shutdown events
  logic [TMR_W-1:0]     short_limit;   // Selected short-circuit delay
  logic [NUM_SW-1:0]    nxt_switch_on;
  logic [NUM_SW-1:0]    nxt_ol_pull;
  logic [WORD_W-1:0]    nxt_status;

  // Serial input shifter, cleared count at every chip select high
  // Async clear by chip select only loads constants; the word itself is
  // kept so the oscillator domain can read it after the frame ends.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx_cnt_ff <= '0;                                   // see (RQ1)
    end else begin
      if (rx_cnt_ff != FRAME_BITS) begin
        rx_cnt_ff <= rx_cnt_ff + 5'h01;
      end
    end
  end

  // Data bits enter at the top so bit 0 ends at the bottom
  always_ff @(negedge sclk) begin
    if (!cs_n) begin
      rx_shift_ff <= {serial_in, rx_shift_ff[WORD_W-1:1]}; // see (RQ2)
    end
  end

  // Word-complete flag, dropped by the first bit of the next frame
  always_ff @(negedge sclk) begin
    if (!cs_n) begin
      if (rx_cnt_ff == '0) begin
        frame_full_ff <= 1'b0;                           // see (RQ20)
      end else if (rx_cnt_ff == FRAME_BITS - 5'h01) begin
        frame_full_ff <= 1'b1;
      end
    end
  end

  // Output bit index: the first rise keeps bit 0, later rises advance
  // Bit 15 comes on the sixteenth rise, so four bits of index suffice.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_idx_ff <= '0;
    end else if (rx_cnt_ff != '0) begin
      tx_idx_ff <= rx_cnt_ff[3:0];                       // see (RQ5)
    end
  end

  // Prewarning bit is on the line as soon as chip select falls
  assign serial_out    = status_ff[tx_idx_ff];           // see (RQ5) (RQ20)
  assign serial_out_oe = ~cs_n;                          // see (RQ4)

  // Two-flop crossing for pins, analog flags and the link flag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= SYNC_IDLE;                              // Idle select, no edge
      sync_ff <= SYNC_IDLE;
    end else if (ce) begin
      meta_ff <= {sense, cs_n, hard_standby_n, frame_full_ff};
      sync_ff <= meta_ff;
    end
  end

  assign sense_s = sync_ff[SYNC_W-1 -: SENSE_W];
  assign cs_s    = sync_ff[2];
  assign inh_s   = sync_ff[1];
  assign full_s  = sync_ff[0];

  // Chip select edge tracking
  // Reset value matches the idle level of chip select.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_prev_ff <= 1'b1;
    end else if (ce) begin
      cs_prev_ff <= cs_s;
    end
  end

  // Only a whole word is executed; a short frame is dropped
  // The word-complete flag crosses with the same two flops as chip select,
  // and it is set before chip select can rise, so it is never late.
  assign commit    = cs_s & ~cs_prev_ff & full_s;        // see (RQ3) (RQ20)
  assign clear_req = commit & rx_shift_ff[CTL_CLEAR_BIT];

  // Control word, preset at reset
  // The shifter is stable here because the serial clock has stopped.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_ff <= CTL_RESET;                              // see (RQ17)
    end else if (ce && commit) begin
      ctrl_ff <= rx_shift_ff;                            // see (RQ3)
    end
  end

  // Combined standby from software bit and pin
  // Either source alone forces standby; both must be high to run.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      standby_ff <= 1'b1;
    end else if (ce) begin
      standby_ff <= ~ctrl_ff[CTL_RUN_BIT] | ~inh_s;      // see (RQ10) (RQ14)
    end
  end

  // Undervoltage delay timer in oscillator cycles
  // Recovery drops the shutdown at once; only the flag is sticky.
  // Holding at the terminal count keeps the shutdown asserted for as
  // long as the undervoltage lasts.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      uv_tmr_ff <= '0;
      uv_off_ff <= 1'b0;
    end else if (ce) begin
      if (!sense_s.uv) begin
        uv_tmr_ff <= '0;
        uv_off_ff <= 1'b0;                               // see (RQ18)
      end else if (uv_tmr_ff == TMR_W'(UV_DELAY_CYC - 1)) begin
        uv_off_ff <= 1'b1;                               // see (RQ18) (RQ24)
      end else begin
        uv_tmr_ff <= uv_tmr_ff + 18'h00001;
      end
    end
  end

  // Supply-fail flag, a new event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      supply_fail_ff <= 1'b0;
    end else if (ce) begin
      if (sense_s.uv && uv_tmr_ff == TMR_W'(UV_DELAY_CYC - 1)) begin
        supply_fail_ff <= 1'b1;                          // see (RQ15) (RQ18)
      end else if (clear_req) begin
        supply_fail_ff <= 1'b0;                          // see (RQ6)
      end
    end
  end

  // Delay chosen by the short-select control bit
  assign short_limit = ctrl_ff[CTL_SHORT_SEL] ? TMR_W'(SHORT_LONG_CYCLES - 1)
                                              : TMR_W'(SHORT_SHORT_CYCLES - 1); // see (RQ9)

  // One short-circuit timer per switch
  // Prewarning skips the wait because the die is already hot.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SW; gi++) begin : g_short
      logic [TMR_W-1:0] tmr_ff;    // Time spent in current limit

      // Counts only while the switch is conducting into a limit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          tmr_ff <= '0;
        end else if (ce) begin
          if (!sense_s.over_current[gi] || short_off_ff[gi]) begin
            tmr_ff <= '0;
          end else if (tmr_ff < short_limit) begin
            tmr_ff <= tmr_ff + 18'h00001;                // see (RQ24)
          end
        end
      end

      // Shutdown event for this switch
      assign short_hit[gi] = sense_s.over_current[gi] & ~short_off_ff[gi] &
                             (sense_s.temp_warn | (tmr_ff >= short_limit)); // see (RQ22)

      // Latched off until the clear bit is written
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          short_off_ff[gi] <= 1'b0;
        end else if (ce) begin
          if (short_hit[gi]) begin
            short_off_ff[gi] <= 1'b1;                    // see (RQ22)
          end else if (clear_req) begin
            short_off_ff[gi] <= 1'b0;                    // see (RQ6) (RQ22)
          end
        end
      end
    end
  endgenerate

  // Short-detected flag, set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      short_flag_ff <= 1'b0;
    end else if (ce) begin
      if (|short_hit) begin
        short_flag_ff <= 1'b1;                           // see (RQ13)
      end else if (clear_req) begin
        short_flag_ff <= 1'b0;                           // see (RQ6)
      end
    end
  end

  // Overtemperature shutdown latch
  // A clear while still hot is refused because the comparator wins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overtemp_ff <= 1'b0;
    end else if (ce) begin
      if (sense_s.temp_shut) begin
        overtemp_ff <= 1'b1;                             // see (RQ16)
      end else if (clear_req) begin
        overtemp_ff <= 1'b0;                             // see (RQ21) (RQ6)
      end
    end
  end

  // Switch drive and open-load pull per output
  always_comb begin
    for (int i = 0; i < NUM_SW; i++) begin
      nxt_switch_on[i] = ctrl_ff[CTL_SW_LSB + i] & ~standby_ff & ~uv_off_ff &
                         ~overtemp_ff & ~short_off_ff[i];  // see (RQ7) (RQ10) (RQ18)
      nxt_ol_pull[i]   = ~ctrl_ff[CTL_OL_BIT] & ~ctrl_ff[CTL_SW_LSB + i]; // see (RQ8) (RQ19)
    end
  end

  // Registered drive outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      switch_on_ff <= '0;
      ol_pull_ff   <= '0;
    end else if (ce) begin
      switch_on_ff <= nxt_switch_on;                     // see (RQ16) (RQ21)
      ol_pull_ff   <= nxt_ol_pull;
    end
  end

  // Status word assembly
  always_comb begin
    nxt_status = '0;
    nxt_status[STS_PREWARN] = sense_s.temp_warn;         // see (RQ11)
    for (int i = 0; i < NUM_SW; i++) begin
      nxt_status[STS_SW_LSB + i] = ol_pull_ff[i] ? sense_s.open_load[i]
                                                 : switch_on_ff[i]; // see (RQ12)
    end
    nxt_status[STS_SHORT]   = short_flag_ff;             // see (RQ13)
    nxt_status[STS_STANDBY] = standby_ff;                // see (RQ14)
    nxt_status[STS_SUPPLY]  = supply_fail_ff;            // see (RQ15)
    if (overtemp_ff) begin
      nxt_status = STS_ALL_HIGH;                         // see (RQ16)
    end
  end

  // Status snapshot, held while a frame runs so the shifter sees a stable word
  // Reset clears it; the first real value lands a few cycles later.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_ff <= '0;
    end else if (ce && cs_s && cs_prev_ff) begin
      status_ff <= nxt_status;
    end
  end

  assign switch_on      = switch_on_ff;
  assign open_load_pull = ol_pull_ff;
  assign standby        = standby_ff;

endmodule

// file: verification/hbc_top_asserts.sv
// Port-level concurrent checks for the half-bridge serial control block
`timescale 1ns/1ps
module hbc_top_asserts
  import hbc_pkg::*;
#(
  parameter int SHORT_LONG_CYCLES  = SHORT_LONG_CYC,
  parameter int SHORT_SHORT_CYCLES = SHORT_SHORT_CYC
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              cs_n,
  input wire logic              serial_out,
  input wire logic              serial_out_oe,
  input wire logic              hard_standby_n,
  input wire hbc_sense_t        sense,
  input wire logic [NUM_SW-1:0] switch_on,
  input wire logic [NUM_SW-1:0] open_load_pull,
  input wire logic              standby
);
  logic [9:0]  uv_cnt_ff;  // Undervoltage run length
  logic [17:0] oc_cnt_ff;  // Current limit run length, switch one
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Saturating, so a long fault never wraps back under the limit
  always_ff @(posedge clk) begin
    if (!rst_n || !sense.uv) uv_cnt_ff <= '0;
    else if (uv_cnt_ff != '1) uv_cnt_ff <= uv_cnt_ff + 10'h1;
  end
  // Same idea for the short timer on the first switch
  always_ff @(posedge clk) begin
    if (!rst_n || !sense.over_current[0]) oc_cnt_ff <= '0;
    else if (oc_cnt_ff != '1) oc_cnt_ff <= oc_cnt_ff + 18'h1;
  end
  a_oe_select: assert property (
    serial_out_oe == !cs_n) else $error("data out enable does not follow select");
  a_standby_off: assert property (
    standby && $past(standby) && $past(standby, 2) |-> switch_on == '0)
    else $error("switch on during standby");
  a_pin_standby: assert property (
    (!hard_standby_n)[*6] |-> standby) else $error("pin low without standby");
  a_standby_exit: assert property (
    $fell(standby) |-> $past(hard_standby_n, 2)) else $error("standby left with pin low");
  a_pull_excl: assert property (
    $stable(switch_on) && $stable(open_load_pull) |-> (switch_on & open_load_pull) == '0)
    else $error("load pull on a driven switch");
  a_shut_all_high: assert property (
    $fell(cs_n) && sense.temp_shut && $past(sense.temp_shut, 8) |-> ##2 serial_out)
    else $error("status not all high in shutdown");
  a_uv_delay: assert property (
    uv_cnt_ff > 10'(UV_DELAY_CYC + 8) |-> switch_on == '0)
    else $error("outputs live after undervoltage delay");
  a_short_delay: assert property (
    oc_cnt_ff > 18'(SHORT_LONG_CYCLES + 6) |-> !switch_on[0])
    else $error("shorted switch still on");
  c_standby: cover property ($rose(standby));
  c_uv_long: cover property (uv_cnt_ff > 10'd100);
  c_prewarn_read: cover property ($fell(cs_n) && sense.temp_warn);
endmodule
bind hbc_top hbc_top_asserts #(
  .SHORT_LONG_CYCLES (SHORT_LONG_CYCLES),
  .SHORT_SHORT_CYCLES(SHORT_SHORT_CYCLES)
) u_chk (
  .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .hard_standby_n(hard_standby_n),
  .sense(sense), .switch_on(switch_on), .open_load_pull(open_load_pull),
  .standby(standby)
);

// file: verification/hbc_host.sv
// Host serial master model driving the control link
`timescale 1ns/1ps
module hbc_host (
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  input  wire  sdo
);
  // Idle link: clock still, deselected, data at pull-down level
  // Link period of 6 ns is fixed for the bench run time
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    serial_in = 1'b0;
    #1 cs_n = 1'b1; // A sure rise clears the link counters, which have no reset
  end
  // One exchange; fewer than 16 bits aborts the frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    cs_n = 1'b0;
    #200;
    for (int k = 0; k < n; k++) begin
      #3 sclk = 1'b1;
      serial_in = w[k];
      #3 r[k] = sdo;
      sclk = 1'b0;
    end
    #3 cs_n = 1'b1;
    serial_in = 1'b0;
  endtask
endmodule

// file: verification/test_hbc_top.sv
// Self-checking bench for the half-bridge serial control block
`timescale 1ns/1ps
module test_hbc_top
  import hbc_pkg::*;
;
  typedef struct packed {
    logic [15:0] w;
    logic        hsn;
    logic [11:0] sw;
    logic        sb;
  } hbc_row_t;
  logic              clk, rst_n, ce, hard_standby_n;
  logic              sclk, cs_n, serial_in, serial_out, serial_out_oe, standby;
  hbc_sense_t        sense;
  logic [NUM_SW-1:0] switch_on, open_load_pull;
  logic [15:0]       rd;  // Status word seen by the host
  int                fail_count, total_checks, cyc;
  wire               sdo = serial_out_oe ? serial_out : 1'bz;  // Shared return line
  // Control word, pin, expected switches and standby
  hbc_row_t rows [5] = '{
    '{16'ha002, 1'b1, 12'h001, 1'b0}, '{16'hbffe, 1'b1, 12'hfff, 1'b0},
    '{16'h2554, 1'b1, 12'h000, 1'b1}, '{16'heaaa, 1'b1, 12'h555, 1'b0},
    '{16'ha002, 1'b0, 12'h000, 1'b1}};

  hbc_top #(.SHORT_LONG_CYCLES(40), .SHORT_SHORT_CYCLES(10)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .hard_standby_n(hard_standby_n),
    .sense(sense), .switch_on(switch_on),
    .open_load_pull(open_load_pull), .standby(standby));
  hbc_host host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .sdo(sdo));

  always #25 clk = ~clk;
  // Hang guard, well above the cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks=%0d failures=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic swc(input logic [11:0] e);
    chk({4'h0, switch_on}, {4'h0, e});
  endtask
  // Inputs move one ns after the edge, off the sampling point
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Full frame, then time for commit and output stage
  task automatic wr(input logic [15:0] w);
    host.xfer(w, 16, rd);
    tick(10);
  endtask
  // Clear and enable switch one, then hold a current limit on it
  task automatic short_run(input logic [15:0] w, input int t_on, input int t_off);
    wr(w);
    swc(12'h001);
    sense.over_current = 12'h001;
    tick(t_on);
    swc(12'h001);
    tick(t_off);
    swc(12'h000);
    sense.over_current = 12'h000;
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    hard_standby_n = 1'b1;
    sense = '0;
    tick(8);
    rst_n = 1'b1;
    tick(6);
    // Ordinary words: write, check outputs, read status back
    foreach (rows[i]) begin
      hard_standby_n = rows[i].hsn;
      wr(rows[i].w);
      swc(rows[i].sw);
      chk({15'h0, standby}, {15'h0, rows[i].sb});
      wr(rows[i].w);
      chk(rd, {1'b0, rows[i].sb, 1'b0, rows[i].sw, 1'b0});
    end
    // Second reset in mid-run
    hard_standby_n = 1'b1;
    rst_n = 1'b0;
    tick(8);
    rst_n = 1'b1;
    tick(6);
    swc(12'h000);
    chk({15'h0, standby}, 16'h0000);
    chk({4'h0, open_load_pull}, 16'h0000);
    chk({15'h0, serial_out_oe}, 16'h0000);
    wr(16'he000);
    chk(rd, 16'h0000);
    // Open-load detection with one switch on
    sense.open_load = 12'h0f0;
    wr(16'h8002);
    chk({4'h0, open_load_pull}, 16'h0ffe);
    wr(16'h8002);
    chk(rd, 16'h01e2);
    sense.open_load = 12'h000;
    // Prewarning read by an aborted one-bit frame
    sense.temp_warn = 1'b1;
    tick(6);
    host.xfer(16'hffff, 1, rd);
    tick(10);
    chk(rd, 16'h0001);
    chk({4'h0, open_load_pull}, 16'h0ffe);
    short_run(16'h8003, 0, 7);
    sense.temp_warn = 1'b0;
    tick(4);
    short_run(16'h8003, 7, 10);
    wr(16'h8002);
    chk(rd, 16'h2000);
    short_run(16'hc003, 30, 25);
    // Undervoltage: delay, recovery, sticky flag
    wr(16'h8003);
    sense.uv = 1'b1;
    tick(300);
    swc(12'h001);
    tick(120);
    swc(12'h000);
    sense.uv = 1'b0;
    tick(6);
    swc(12'h001);
    wr(16'h8002);
    chk(rd, 16'h8002);
    wr(16'h8003);
    wr(16'h8002);
    chk(rd, 16'h0002);
    // Overtemperature shutdown and release
    sense.temp_shut = 1'b1;
    tick(8);
    swc(12'h000);
    wr(16'h8002);
    chk(rd, 16'hffff);
    sense.temp_shut = 1'b0;
    tick(6);
    swc(12'h000);
    wr(16'h8003);
    swc(12'h001);
    close_out();
  end
endmodule
